// File: common/uhcs_regs.svh
`ifndef UHCS_REGS_SVH
`define UHCS_REGS_SVH
// Register byte addresses on the memory-mapped port
`define UHCS_CMD_ADDR 8'h20
`define UHCS_STS_ADDR 8'h24
// Command register fields
`define UHCS_CMD_RUN 0
`define UHCS_CMD_FRST 1
`define UHCS_CMD_FLL_LO 2
`define UHCS_CMD_FLL_HI 3
`define UHCS_CMD_LRST 7
// Command register reset value, reserved bits included
`define UHCS_CMD_RESET 32'h00080B00
// Status register fields
`define UHCS_STS_PCHG 2
`define UHCS_STS_FROLL 3
// Microframe period in ns and its cycle count at 125 MHz
`define UHCS_UFRAME_NS 125000
`define UHCS_CLK_NS 8
`define UHCS_UFRAME_CYC (`UHCS_UFRAME_NS / `UHCS_CLK_NS)
// Cycles the internal full reset is held before the bit self-clears
`define UHCS_FRST_CYC 16
`endif

// File: common/uhcs_pkg.sv
package uhcs_pkg;
  // Internal reset sequencer states
  typedef enum logic [1:0] {
    UHCS_IDLE,
    UHCS_FULL,
    UHCS_LIGHT
  } uhcs_rst_t;
  // Frame list length selection
  typedef logic [1:0] uhcs_fll_t;
endpackage : uhcs_pkg

// File: rtl/uhcs_frame_ctr.sv
`timescale 1ns/10ps
`include "uhcs_regs.svh"
// Microframe timer and frame index counter
module uhcs_frame_ctr
  import uhcs_pkg::*;
#(
  parameter int UFRAME_CYC = `UHCS_UFRAME_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic run,
  input wire uhcs_fll_t fll,
  output logic [13:0] index,
  output logic rollover
);
  logic [16:0] tick_r;
  logic tick_end;
  logic [13:0] next_idx;
  logic [13:0] wrap_mask;
  assign tick_end = (tick_r == 17'(UFRAME_CYC - 1));
  assign next_idx = index + 14'h0001;
  // Used index bits wrap at 1024, 512 or 256 frames of 8 microframes
  assign wrap_mask = (fll == 2'h0) ? 14'h1FFF :
                     (fll == 2'h1) ? 14'h0FFF : 14'h07FF;
  // Count microframes only while running
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_r <= 17'h00000;
      index <= 14'h0000;
      rollover <= 1'b0;
    end else if (clr || !run) begin
      tick_r <= 17'h00000;
      rollover <= 1'b0;
      if (clr) begin
        index <= 14'h0000;
      end
    end else begin
      rollover <= 1'b0;
      tick_r <= tick_end ? 17'h00000 : tick_r + 17'h00001;
      if (tick_end) begin
        index <= next_idx;
        // Rollover when the used index bits go back to zero
        rollover <= ((next_idx & wrap_mask) == 14'h0000);
      end
    end
  end
endmodule : uhcs_frame_ctr

// File: rtl/uhcs_cmd_sts.sv
`timescale 1ns/10ps
`include "uhcs_regs.svh"
module uhcs_cmd_sts
  import uhcs_pkg::*;
#(
  parameter int NPORTS = 3,
  parameter bit LIGHT_RST_EN = 1'b1,
  parameter int UFRAME_CYC = `UHCS_UFRAME_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] WDATA,
  output logic [31:0] RDATA,
  input wire logic [NPORTS-1:0] PORT_CHANGE,
  input wire logic [NPORTS-1:0] PORT_OWNED,
  input wire logic [NPORTS-1:0] FORCE_RESUME,
  output logic RUN,
  output logic FULL_RESET,
  output logic LIGHT_RESET,
  output logic [13:0] FRAME_INDEX
);
  logic [31:0] cmd_r;
  logic [31:0] cmd_nxt;
  logic pchg_r;
  logic froll_r;
  uhcs_rst_t rst_st_r;
  logic [4:0] rst_cnt_r;
  logic cmd_wr;
  logic sts_wr;
  logic resetting;
  logic [NPORTS-1:0] chg_d_r;
  logic [NPORTS-1:0] fpr_d_r;
  logic [NPORTS-1:0] port_ev;
  logic port_event;
  logic rollover;
  logic [31:0] cmd_view;
  logic [31:0] sts_view;
  // Address decode
  assign cmd_wr = WR && (ADDR == `UHCS_CMD_ADDR);
  assign sts_wr = WR && (ADDR == `UHCS_STS_ADDR);
  assign resetting = (rst_st_r != UHCS_IDLE);
  // Per-port rising edges; companion-owned ports count only force resume edges
  generate
    for (genvar p = 0; p < NPORTS; p++) begin : g_port
      assign port_ev[p] =
        (PORT_CHANGE[p] && !chg_d_r[p] && !PORT_OWNED[p])
        || (FORCE_RESUME[p] && !fpr_d_r[p]);
    end
  endgenerate
  assign port_event = |port_ev;
  // Next command value; reset bits self-clear when the sequencer ends
  always_comb begin
    cmd_nxt = cmd_r;
    if (cmd_wr) begin
      cmd_nxt = WDATA;
      if (!LIGHT_RST_EN) begin
        cmd_nxt[`UHCS_CMD_LRST] = 1'b0;
      end
    end
    if (rst_st_r == UHCS_FULL && rst_cnt_r == 5'h00) begin
      cmd_nxt = `UHCS_CMD_RESET;
    end
    if (rst_st_r == UHCS_LIGHT && rst_cnt_r == 5'h00) begin
      cmd_nxt[`UHCS_CMD_LRST] = 1'b0;
      cmd_nxt[`UHCS_CMD_RUN] = 1'b0;
    end
  end
  // Command register and reset sequencer
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cmd_r <= `UHCS_CMD_RESET;
      rst_st_r <= UHCS_IDLE;
      rst_cnt_r <= 5'h00;
    end else begin
      cmd_r <= cmd_nxt;
      case (rst_st_r)
        UHCS_IDLE: begin
          if (cmd_wr && WDATA[`UHCS_CMD_FRST]) begin
            rst_st_r <= UHCS_FULL;
            rst_cnt_r <= 5'(`UHCS_FRST_CYC - 1);
          end else if (cmd_wr && WDATA[`UHCS_CMD_LRST] && LIGHT_RST_EN) begin
            rst_st_r <= UHCS_LIGHT;
            rst_cnt_r <= 5'(`UHCS_FRST_CYC - 1);
          end
        end
        UHCS_FULL, UHCS_LIGHT: begin
          if (rst_cnt_r == 5'h00) begin
            rst_st_r <= UHCS_IDLE;
          end else begin
            rst_cnt_r <= rst_cnt_r - 5'h01;
          end
        end
        default: rst_st_r <= UHCS_IDLE;
      endcase
    end
  end
  // Status flags: set beats a write-one clear in the same cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pchg_r <= 1'b0;
      froll_r <= 1'b0;
      chg_d_r <= '0;
      fpr_d_r <= '0;
    end else begin
      chg_d_r <= PORT_CHANGE;
      fpr_d_r <= FORCE_RESUME;
      if (rst_st_r == UHCS_FULL) begin
        pchg_r <= 1'b0;
        froll_r <= 1'b0;
      end else begin
        pchg_r <= port_event ||
          (pchg_r && !(sts_wr && WDATA[`UHCS_STS_PCHG]));
        froll_r <= rollover ||
          (froll_r && !(sts_wr && WDATA[`UHCS_STS_FROLL]));
      end
    end
  end
  // Frame counter; both resets restart it, light reset spares ports
  uhcs_frame_ctr #(.UFRAME_CYC(UFRAME_CYC)) u_frame (
    .clk(CLK),
    .rst(RST),
    .clr(resetting),
    .run(cmd_r[`UHCS_CMD_RUN] && !resetting),
    .fll(cmd_r[`UHCS_CMD_FLL_HI:`UHCS_CMD_FLL_LO]),
    .index(FRAME_INDEX),
    .rollover(rollover)
  );
  // Read views; status carries only flags, never transaction results
  assign cmd_view = cmd_r;
  assign sts_view = {28'h0000000, froll_r, pchg_r, 2'h0};
  // Read data register
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RDATA <= 32'h00000000;
    end else if (RD) begin
      RDATA <= (ADDR == `UHCS_CMD_ADDR) ? cmd_view :
               (ADDR == `UHCS_STS_ADDR) ? sts_view : 32'h00000000;
    end
  end
  assign RUN = cmd_r[`UHCS_CMD_RUN] && !resetting;
  assign FULL_RESET = (rst_st_r == UHCS_FULL);
  assign LIGHT_RESET = (rst_st_r == UHCS_LIGHT);
  // Checks
  property p_full_rst;
    @(posedge CLK) disable iff (RST)
    (cmd_wr && WDATA[`UHCS_CMD_FRST] && !resetting) |=> FULL_RESET[*8];
  endproperty
  a_full_rst: assert property (p_full_rst)
    else $error("no full reset");
  property p_self_clear;
    @(posedge CLK) disable iff (RST)
    $fell(FULL_RESET) |-> !cmd_r[`UHCS_CMD_FRST];
  endproperty
  a_self_clear: assert property (p_self_clear)
    else $error("bit stuck");
  property p_w1c;
    @(posedge CLK) disable iff (RST)
    (sts_wr && WDATA[`UHCS_STS_FROLL] && !rollover && !FULL_RESET)
      |=> !froll_r;
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared");
  property p_roll;
    @(posedge CLK) disable iff (RST)
    rollover && !FULL_RESET |=> froll_r;
  endproperty
  a_roll: assert property (p_roll) else $error("rollover lost");
  property p_pchg;
    @(posedge CLK) disable iff (RST)
    port_event && !FULL_RESET |=> pchg_r;
  endproperty
  a_pchg: assert property (p_pchg) else $error("port change lost");
  property p_stop;
    @(posedge CLK) disable iff (RST)
    !RUN |=> $stable(FRAME_INDEX) || $past(resetting);
  endproperty
  a_stop: assert property (p_stop) else $error("index moved");
  property p_sts_hi;
    @(posedge CLK) disable iff (RST)
    $past(RD) && $past(ADDR) == `UHCS_STS_ADDR |-> RDATA[31:4] == 28'h0;
  endproperty
  a_sts_hi: assert property (p_sts_hi) else $error("status high set");
  property p_light;
    @(posedge CLK) disable iff (RST)
    (cmd_wr && WDATA[`UHCS_CMD_LRST] && !WDATA[`UHCS_CMD_FRST]
      && !resetting) |=> (LIGHT_RESET == LIGHT_RST_EN);
  endproperty
  a_light: assert property (p_light) else $error("light reset");
  c_full: cover property (@(posedge CLK) $fell(FULL_RESET));
  c_roll: cover property (@(posedge CLK) rollover);
  c_pchg: cover property (@(posedge CLK) port_event);
  c_light: cover property (@(posedge CLK) $fell(LIGHT_RESET));
  // A build without light reset never keeps bit 7 after a write
  property p_no_light;
    @(posedge CLK) disable iff (RST)
    (cmd_wr && !LIGHT_RST_EN) |=> !cmd_r[`UHCS_CMD_LRST];
  endproperty
  a_no_light: assert property (p_no_light) else $error("bit 7 set");
  // Light reset drops its bit as the sequence ends, so it can be polled
  property p_light_end;
    @(posedge CLK) disable iff (RST)
    $fell(LIGHT_RESET) |-> !cmd_r[`UHCS_CMD_LRST];
  endproperty
  a_light_end: assert property (p_light_end) else $error("lr stuck");
  // Index only steps by one or restarts at zero; a skip would lose frames
  property p_idx_step;
    @(posedge CLK) disable iff (RST)
    !$stable(FRAME_INDEX) |->
      (FRAME_INDEX == $past(FRAME_INDEX) + 14'h0001) ||
      (FRAME_INDEX == 14'h0000);
  endproperty
  a_idx_step: assert property (p_idx_step) else $error("index jump");
endmodule : uhcs_cmd_sts

// File: verif/uhcs_port_model.sv
`timescale 1ns/10ps
// Port side: per-port levels whose rising edges are the change events
module uhcs_port_model #(
  parameter int NPORTS = 3
) (
  input wire logic clk,
  output logic [NPORTS-1:0] chg,
  output logic [NPORTS-1:0] owned,
  output logic [NPORTS-1:0] fres
);
  // All ports quiet and locally owned at start
  initial begin
    chg = '0;
    owned = '0;
    fres = '0;
  end
  // Kind 0 change, 1 change on companion port, 2 force resume
  task automatic raise(input int kind, input int port);
    @(negedge clk);
    owned[port] = (kind == 1);
    // Owned bit set with the edge so it cannot count
    if (kind == 2) begin
      fres[port] = 1'b1;
    end else begin
      chg[port] = 1'b1;
    end
    @(negedge clk);
    chg[port] = 1'b0;
    fres[port] = 1'b0;
  endtask : raise
endmodule : uhcs_port_model

// File: verif/usb_host_command_status_regs_test.sv
`timescale 1ns/10ps
// Register bank bench, driven at the falling edge
module usb_host_command_status_regs_test;
  logic clk, rst, wr, rd;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [2:0] chg, owned, fres;
  logic run, full_rst, light_rst;
  logic [13:0] frame_index;
  logic [13:0] idx; // Last seen index
  logic [31:0] rdata_lite; // Read data of the copy without light reset
  logic lrst_lite; // Light reset output of that copy
  int n, error_cnt, tests_run;
  // Run bit plus 256-frame list, reserved bits at reset value
  localparam logic [31:0] CMD_RUN = 32'h00080B09;
  uhcs_cmd_sts #(.UFRAME_CYC(16)) u_uhcs_cmd_sts (
    .CLK(clk), .RST(rst), .ADDR(addr), .WR(wr), .RD(rd),
    .WDATA(wdata), .RDATA(rdata), .PORT_CHANGE(chg),
    .PORT_OWNED(owned), .FORCE_RESUME(fres), .RUN(run),
    .FULL_RESET(full_rst), .LIGHT_RESET(light_rst),
    .FRAME_INDEX(frame_index)
  );
  uhcs_port_model #(.NPORTS(3)) u_uhcs_port_model (
    .clk(clk), .chg(chg), .owned(owned), .fres(fres)
  );
  // Second copy built without light reset, on the same bus and ports
  if (1) begin : g_lite
    uhcs_cmd_sts #(.UFRAME_CYC(16), .LIGHT_RST_EN(1'b0)) u_uhcs_cmd_sts (
      .CLK(clk), .RST(rst), .ADDR(addr), .WR(wr), .RD(rd),
      .WDATA(wdata), .RDATA(rdata_lite), .PORT_CHANGE(chg),
      .PORT_OWNED(owned), .FORCE_RESUME(fres), .RUN(),
      .FULL_RESET(), .LIGHT_RESET(lrst_lite), .FRAME_INDEX()
    );
  end
  // Clock at 8 ns
  always #4 clk = ~clk;
  // Compare one value, four-state exact
  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  // Write strobe held across exactly one rising edge
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr_reg
  // Read data is registered, so sample one cycle after the strobe
  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] exp);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk(nm, exp, rdata);
  endtask : rd_chk
  // Single place where the run ends
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // Watchdog well beyond the rollover wait of about 33k cycles
  initial begin
    #400000;
    error_cnt++;
    print_verdict();
  end
  // Main sequence
  initial begin
    clk = 0;
    rst = 1;
    wr = 0;
    rd = 0;
    addr = 0;
    wdata = 0;
    error_cnt = 0;
    tests_run = 0;
    repeat (20) @(negedge clk);
    rst = 0;
    rd_chk("cmd_rst", 8'h20, 32'h00080B00);
    rd_chk("sts_rst", 8'h24, 32'h0);
    chk("run_rst", 32'h0, run);
    rd_chk("unmapped", 8'h30, 32'h0);
    $display("test reset done");
    u_uhcs_port_model.raise(0, 0);
    rd_chk("pchg_set", 8'h24, 32'h4);
    wr_reg(8'h24, 32'h0);
    rd_chk("pchg_w0", 8'h24, 32'h4);
    wr_reg(8'h24, 32'h4);
    rd_chk("pchg_w1", 8'h24, 32'h0);
    u_uhcs_port_model.raise(1, 1);
    rd_chk("pchg_owned", 8'h24, 32'h0);
    u_uhcs_port_model.raise(2, 2);
    rd_chk("pchg_fres", 8'h24, 32'h4);
    wr_reg(8'h24, 32'h4);
    $display("test port events done");
    wr_reg(8'h20, CMD_RUN);
    @(negedge clk);
    chk("run_on", 32'h1, run);
    rd_chk("cmd_run", 8'h20, CMD_RUN);
    // Align to an index step, then time the next one
    idx = frame_index;
    for (n = 0; n < 40 && frame_index === idx; n++) @(negedge clk);
    idx = frame_index;
    for (n = 0; n < 40 && frame_index === idx; n++) @(negedge clk);
    chk("uframe", 32'h10, n);
    rd_chk("froll_pre", 8'h24, 32'h0);
    // A 256-frame list wraps when bit 11 of the index first sets
    for (n = 0; n < 40000 && frame_index !== 14'h0800; n++) begin
      @(negedge clk);
    end
    rd_chk("froll_set", 8'h24, 32'h8);
    wr_reg(8'h24, 32'h8);
    rd_chk("froll_clr", 8'h24, 32'h0);
    $display("test rollover done");
    wr_reg(8'h20, CMD_RUN | 32'h80);
    @(negedge clk);
    chk("light_on", 32'h1, light_rst);
    chk("lite_lrst", 32'h0, lrst_lite);
    rd_chk("cmd_light", 8'h20, CMD_RUN | 32'h80);
    chk("lite_cmd", CMD_RUN, rdata_lite);
    repeat (20) @(negedge clk);
    chk("light_run", 32'h0, run);
    chk("light_idx", 32'h0, frame_index);
    $display("test light reset done");
    u_uhcs_port_model.raise(0, 0);
    wr_reg(8'h20, 32'h00080B02);
    @(negedge clk);
    chk("full_on", 32'h1, full_rst);
    rd_chk("cmd_busy", 8'h20, 32'h00080B02);
    repeat (20) @(negedge clk);
    chk("full_off", 32'h0, full_rst);
    rd_chk("cmd_done", 8'h20, 32'h00080B00);
    rd_chk("sts_done", 8'h24, 32'h0);
    $display("test full reset done");
    print_verdict();
  end
endmodule : usb_host_command_status_regs_test
